// ---- hdl/cag_consts.svh ----
// Purpose: Constants for the address generation block.
// Assumes: 16-bit address space, four banks of eight byte registers.
// Notes: Offsets and field positions are macros; types live in the package.
// Function
// RULE1: Sequential fetch advances the program counter by one per fetched byte.
// RULE2: Relative target is sign-extended displacement plus next instruction start.
// RULE3: Short branch and all conditional branches use the relative target.
// RULE4: Long call and long branch load the full 16-bit immediate.
// RULE5: Fast call target is 11-bit immediate placed in 0800H to 0FFFH.
// RULE6: Table call reads 16-bit entry at 40H-7FH indexed by opcode bits 1-5.
// RULE7: Register-pair branch copies the accumulator pair into the program counter.
// RULE8: Multiply takes accumulator byte times auxiliary byte, product to pair.
// RULE9: Word divide reads dividend from accumulator pair, writes quotient there.
// RULE10: Decimal adjust and digit rotations implicitly use the accumulator byte.
// RULE11: Register operand uses bank flags and a 3-bit opcode register field.
// RULE12: Direct addressing uses the 16-bit immediate unchanged.
// RULE13: Short direct sets bit 8 only for immediates 00H to 1FH.
// RULE14: Short direct window covers RAM FE20H-FEFFH and registers FF00H-FF1FH.
// RULE15: Software gives only even addresses for word short direct access.
// RULE16: Special register addressing uses 8-bit immediate over 240 bytes.
// RULE17: Word special register access names only even word-capable registers.
// RULE18: Register indirect uses the selected pointer pair of the current bank.
// RULE19: Based address adds zero-extended offset to base pair, carry dropped.
// RULE20: General registers sit at FEE0H-FEFFH as four banks of eight.
// RULE21: Special register address has FFH as its upper byte.
`ifndef CAG_CONSTS_SVH
`define CAG_CONSTS_SVH
`define CAG_FAST_CALL_BASE   16'h0800
`define CAG_TABLE_BASE       16'h0040
`define CAG_SHORT_HIGH_BYTE  8'hFE
`define CAG_SHORT_LIMIT      8'h20
`define CAG_SFR_HIGH_BYTE    8'hFF
`define CAG_GREG_BASE        16'hFEE0
`define CAG_REG_X            3'h0
`define CAG_REG_A            3'h1
`define CAG_PAIR_AX          2'h0
`define CAG_PAIR_DE          2'h2
`define CAG_PAIR_HL          2'h3
`endif

// ---- hdl/cag_pkg.sv ----
// Purpose: Types for the address generation block.
// Assumes: Used only through scoped names.
// Notes: Command encodings carry no fixed codes.
package cag_pkg;
    typedef enum logic [3:0] {
        CAG_PC_HOLD, CAG_PC_SEQ, CAG_PC_REL, CAG_PC_IMM16, CAG_PC_FAST,
        CAG_PC_TABLE, CAG_PC_PAIR
    } cag_pc_op_t;
    typedef enum logic [3:0] {
        CAG_EA_NONE, CAG_EA_REG, CAG_EA_DIRECT, CAG_EA_SHORT, CAG_EA_SFR,
        CAG_EA_INDIRECT, CAG_EA_BASED, CAG_EA_UNSIGNED_MULTIPLY_OP, CAG_EA_WORD_DIVISION_OP, CAG_EA_ACC
    } cag_ea_op_t;
    typedef struct packed {
        cag_pc_op_t  pc_op;
        cag_ea_op_t  ea_op;
        logic [15:0] imm16;
        logic [7:0]  opcode;
        logic [1:0]  bank;
        logic        pair_hl;
    } cag_req_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] addr_hi;
        logic        word;
        logic        valid;
    } cag_ea_t;
    typedef enum {CAG_IDLE, CAG_TBL_LO, CAG_TBL_HI} cag_state_t;
endpackage

// ---- hdl/cag_regfile.sv ----
// Purpose: General register storage, four banks of eight bytes.
// Assumes: Two read ports, registered read data; one byte write port.
// Notes: Index is bank times eight plus register number.
`timescale 1ns/100ps
module cag_regfile #(
    parameter int DEPTH = 32
) (
    input  wire logic        clk,
    input  wire logic [4:0]  ra_idx,
    input  wire logic [4:0]  rb_idx,
    input  wire logic        we,
    input  wire logic [4:0]  w_idx,
    input  wire logic [7:0]  w_data,
    output      logic [7:0]  ra_data,
    output      logic [7:0]  rb_data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[w_idx] <= w_data;
        end
        ra_data <= mem[ra_idx];
        rb_data <= mem[rb_idx];
    end
endmodule // cag_regfile

// ---- hdl/cag_top.sv ----
// Purpose: Program counter and operand address generation of an 8-bit core.
// Assumes: One request per idle cycle; table entries arrive on the memory read port.
// Notes: PC and EA results come out one cycle after the request, the product two, table calls take three.
`timescale 1ns/100ps
`include "cag_consts.svh"
module cag_top (
    input  wire logic             MCLK,
    input  wire logic             ARST_N,
    input  wire logic             REQ_VALID,
    input  wire cag_pkg::cag_req_t REQ,
    input  wire logic [1:0]       FETCH_BYTES,
    input  wire logic [7:0]       MEM_RDATA,
    input  wire logic             REG_WE,
    input  wire logic [4:0]       REG_WIDX,
    input  wire logic [7:0]       REG_WDATA,
    output      logic [15:0]      PC,
    output      logic             PC_VALID,
    output      logic [15:0]      TBL_ADDR,
    output      logic             TBL_RD,
    output      cag_pkg::cag_ea_t EA,
    output      logic [15:0]      PRODUCT,
    output      logic             BUSY
);
    logic rst_meta_q, rst_n_q;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    function automatic logic [4:0] reg_index(input logic [1:0] bank,
                                             input logic [2:0] num);
        reg_index = {bank, num}; // RULE11 RULE20
    endfunction

    // Byte address of a general register: base plus bank times eight plus register number.
    function automatic logic [15:0] greg_addr(input logic [1:0] bank,
                                              input logic [2:0] num);
        greg_addr = `CAG_GREG_BASE | {11'h000, reg_index(bank, num)}; // RULE20
    endfunction

    // Shadow copy of the register file so pairs are readable combinationally.
    logic [7:0] greg_q [32];
    logic [7:0] greg_d [32];
    always_comb begin
        greg_d = greg_q;
        if (REG_WE) begin
            greg_d[REG_WIDX] = REG_WDATA;
        end
    end
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < 32; i++) begin
                greg_q[i] <= 8'h00;
            end
        end else begin
            greg_q <= greg_d;
        end
    end

    function automatic logic [15:0] pair_val(input logic [1:0] bank,
                                             input logic [1:0] pr);
        pair_val = {greg_q[reg_index(bank, {pr, 1'b1})],
                    greg_q[reg_index(bank, {pr, 1'b0})]};
    endfunction

    logic [7:0] rf_a, rf_b;
    cag_regfile #(.DEPTH(32)) u_rf (
        .clk    (MCLK),
        .ra_idx (reg_index(REQ.bank, `CAG_REG_A)),
        .rb_idx (reg_index(REQ.bank, `CAG_REG_X)),
        .we     (REG_WE),
        .w_idx  (REG_WIDX),
        .w_data (REG_WDATA),
        .ra_data(rf_a),
        .rb_data(rf_b)
    );

    cag_pkg::cag_state_t state_q, state_d;
    logic [15:0] pc_q, pc_d, tbl_q, tbl_d;
    logic        pcv_q, pcv_d, tblrd_q, tblrd_d, mul_q, mul_d;
    // Busy is kept in its own flop so the output does not ripple through the state decode.
    logic        busy_q, busy_d;
    logic [7:0]  lo_q, lo_d;
    cag_pkg::cag_ea_t ea_q, ea_d;
    logic [15:0] prod_q, prod_d;
    logic [15:0] next_seq;
    logic [7:0]  disp;

    always_comb begin
        state_d  = state_q;
        pc_d     = pc_q;
        pcv_d    = 1'b0;
        tbl_d    = tbl_q;
        tblrd_d  = 1'b0;
        lo_d     = lo_q;
        ea_d     = '0;
        mul_d    = 1'b0;
        prod_d   = prod_q;
        next_seq = pc_q + {14'h0000, FETCH_BYTES}; // RULE1
        disp     = REQ.imm16[7:0];
        if (mul_q) begin
            // Both factors are widened first so the upper product byte is never lost.
            prod_d = {8'h00, rf_a} * {8'h00, rf_b}; // RULE8
        end
        case (state_q)
            cag_pkg::CAG_IDLE: begin
                if (REQ_VALID) begin
                    case (REQ.pc_op)
                        cag_pkg::CAG_PC_SEQ: begin
                            pc_d  = next_seq; // RULE1
                            pcv_d = 1'b1;
                        end
                        cag_pkg::CAG_PC_REL: begin
                            pc_d  = next_seq + {{8{disp[7]}}, disp}; // RULE2 RULE3
                            pcv_d = 1'b1;
                        end
                        cag_pkg::CAG_PC_IMM16: begin
                            pc_d  = REQ.imm16; // RULE4
                            pcv_d = 1'b1;
                        end
                        cag_pkg::CAG_PC_FAST: begin
                            pc_d  = `CAG_FAST_CALL_BASE | {5'h00, REQ.imm16[10:0]}; // RULE5
                            pcv_d = 1'b1;
                        end
                        cag_pkg::CAG_PC_TABLE: begin
                            tbl_d   = `CAG_TABLE_BASE | {10'h000, REQ.opcode[5:1], 1'b0}; // RULE6
                            tblrd_d = 1'b1;
                            state_d = cag_pkg::CAG_TBL_LO;
                        end
                        cag_pkg::CAG_PC_PAIR: begin
                            pc_d  = pair_val(REQ.bank, `CAG_PAIR_AX); // RULE7
                            pcv_d = 1'b1;
                        end
                        default: begin
                            pc_d = pc_q;
                        end
                    endcase
                    ea_d.valid = (REQ.ea_op != cag_pkg::CAG_EA_NONE);
                    case (REQ.ea_op)
                        cag_pkg::CAG_EA_REG: begin
                            ea_d.addr = greg_addr(REQ.bank, REQ.opcode[2:0]); // RULE11
                        end
                        cag_pkg::CAG_EA_DIRECT: begin
                            ea_d.addr = REQ.imm16; // RULE12
                        end
                        cag_pkg::CAG_EA_SHORT: begin
                            ea_d.addr = {`CAG_SHORT_HIGH_BYTE, 8'h00}
                                | {7'h00, REQ.imm16[7:0] < `CAG_SHORT_LIMIT,
                                   REQ.imm16[7:0]}; // RULE13 RULE14
                        end
                        cag_pkg::CAG_EA_SFR: begin
                            ea_d.addr = {`CAG_SFR_HIGH_BYTE, REQ.imm16[7:0]}; // RULE16 RULE21
                        end
                        cag_pkg::CAG_EA_INDIRECT: begin
                            ea_d.addr = pair_val(REQ.bank,
                                REQ.pair_hl ? `CAG_PAIR_HL : `CAG_PAIR_DE); // RULE18
                        end
                        cag_pkg::CAG_EA_BASED: begin
                            ea_d.addr = pair_val(REQ.bank, `CAG_PAIR_HL)
                                + {8'h00, REQ.imm16[7:0]}; // RULE19
                        end
                        cag_pkg::CAG_EA_UNSIGNED_MULTIPLY_OP: begin
                            ea_d.addr = greg_addr(REQ.bank, `CAG_REG_X); // RULE8
                            ea_d.word = 1'b1;
                            mul_d     = 1'b1;
                        end
                        cag_pkg::CAG_EA_WORD_DIVISION_OP: begin
                            ea_d.addr = greg_addr(REQ.bank, `CAG_REG_X); // RULE9
                            ea_d.word = 1'b1;
                        end
                        cag_pkg::CAG_EA_ACC: begin
                            ea_d.addr = greg_addr(REQ.bank, `CAG_REG_A); // RULE10
                        end
                        default: begin
                            ea_d.addr = 16'h0000;
                        end
                    endcase
                    ea_d.addr_hi = ea_d.addr + 16'h0001;
                end
            end
            cag_pkg::CAG_TBL_LO: begin
                lo_d    = MEM_RDATA;
                tbl_d   = tbl_q + 16'h0001;
                tblrd_d = 1'b1;
                state_d = cag_pkg::CAG_TBL_HI;
            end
            cag_pkg::CAG_TBL_HI: begin
                pc_d    = {MEM_RDATA, lo_q}; // RULE6
                pcv_d   = 1'b1;
                state_d = cag_pkg::CAG_IDLE;
            end
            default: begin
                state_d = cag_pkg::CAG_IDLE;
            end
        endcase
        busy_d = (state_d != cag_pkg::CAG_IDLE);
    end

    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= cag_pkg::CAG_IDLE;
            pc_q    <= 16'h0000;
            pcv_q   <= 1'b0;
            tbl_q   <= 16'h0000;
            tblrd_q <= 1'b0;
            lo_q    <= 8'h00;
            ea_q    <= '0;
            mul_q   <= 1'b0;
            prod_q  <= 16'h0000;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            pcv_q   <= pcv_d;
            tbl_q   <= tbl_d;
            tblrd_q <= tblrd_d;
            lo_q    <= lo_d;
            ea_q    <= ea_d;
            mul_q   <= mul_d;
            prod_q  <= prod_d;
            busy_q  <= busy_d;
        end
    end

    assign PC       = pc_q;
    assign PC_VALID = pcv_q;
    assign TBL_ADDR = tbl_q;
    assign TBL_RD   = tblrd_q;
    assign EA       = ea_q;
    assign PRODUCT  = prod_q;
    assign BUSY     = busy_q;
endmodule // cag_top

// ---- test/cag_table_mem.sv ----
// Purpose: Memory model that answers table reads for the address generator.
// Assumes: The addressed byte stands on the data lines while the table read strobe is high.
// Notes: Without a strobe the data lines toggle so a stale byte is never mistaken for an answer.
`timescale 1ns/100ps
module cag_table_mem (
    input  wire logic        MCLK,
    input  wire logic [15:0] TBL_ADDR,
    input  wire logic        TBL_RD,
    output      logic [7:0]  MEM_RDATA
);
    function automatic logic [7:0] tbl_byte(input logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    logic [7:0] idle_q = 8'h00;
    always @(posedge MCLK) begin
        idle_q <= ~idle_q;
    end
    assign MEM_RDATA = TBL_RD ? tbl_byte(TBL_ADDR) : idle_q;
endmodule // cag_table_mem

// ---- test/cag_top_properties.sv ----
// Purpose: Port-level checker for the address generator.
// Assumes: Requests are taken on edges where the strobe is high and the block is idle.
// Notes: Register-dependent results are checked by the bench.
`timescale 1ns/100ps
module cag_top_properties (
    input wire logic             MCLK,
    input wire logic             ARST_N,
    input wire logic             REQ_VALID,
    input wire cag_pkg::cag_req_t REQ,
    input wire logic [1:0]       FETCH_BYTES,
    input wire logic             PC_VALID,
    input wire logic [15:0]      PC,
    input wire logic [15:0]      TBL_ADDR,
    input wire logic             TBL_RD,
    input wire cag_pkg::cag_ea_t EA,
    input wire logic             BUSY
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    wire logic tk = REQ_VALID && !BUSY;
    property p_seq;
        tk && REQ.pc_op == cag_pkg::CAG_PC_SEQ |=> PC_VALID && PC == $past(PC) + 16'($past(FETCH_BYTES));
    endproperty
    a_seq: assert property (p_seq) else $error("sequential step wrong");
    property p_rel;
        tk && REQ.pc_op == cag_pkg::CAG_PC_REL |=> PC_VALID && PC == $past(PC)
            + 16'($past(FETCH_BYTES)) + {{8{$past(REQ.imm16[7])}}, $past(REQ.imm16[7:0])};
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_imm;
        tk && REQ.pc_op == cag_pkg::CAG_PC_IMM16 |=> PC_VALID && PC == $past(REQ.imm16);
    endproperty
    a_imm: assert property (p_imm) else $error("long target wrong");
    property p_fast;
        tk && REQ.pc_op == cag_pkg::CAG_PC_FAST |=> PC_VALID && PC == {5'h01, $past(REQ.imm16[10:0])};
    endproperty
    a_fast: assert property (p_fast) else $error("fast call target wrong");
    property p_tbl;
        tk && REQ.pc_op == cag_pkg::CAG_PC_TABLE |=> TBL_RD && BUSY
            && TBL_ADDR == 16'h0040 + {10'h000, $past(REQ.opcode[5:1]), 1'b0}
            ##1 TBL_RD && TBL_ADDR == $past(TBL_ADDR) + 16'h0001 ##1 PC_VALID;
    endproperty
    a_tbl: assert property (p_tbl) else $error("table walk wrong");
    property p_dir;
        tk && REQ.ea_op == cag_pkg::CAG_EA_DIRECT |=> EA.valid && EA.addr == $past(REQ.imm16);
    endproperty
    a_dir: assert property (p_dir) else $error("direct address wrong");
    property p_short;
        tk && REQ.ea_op == cag_pkg::CAG_EA_SHORT |=> EA.valid
            && EA.addr == {7'h7F, $past(REQ.imm16[7:0]) < 8'h20, $past(REQ.imm16[7:0])};
    endproperty
    a_short: assert property (p_short) else $error("short address wrong");
    property p_sfr;
        tk && REQ.ea_op == cag_pkg::CAG_EA_SFR |=> EA.valid && EA.addr == {8'hFF, $past(REQ.imm16[7:0])};
    endproperty
    a_sfr: assert property (p_sfr) else $error("register space address wrong");
    property p_reg;
        tk && REQ.ea_op == cag_pkg::CAG_EA_REG |=> EA.valid
            && EA.addr == 16'hFEE0 + {11'h000, $past(REQ.bank), $past(REQ.opcode[2:0])};
    endproperty
    a_reg: assert property (p_reg) else $error("register address wrong");
    c_tbl: cover property (tk && REQ.pc_op == cag_pkg::CAG_PC_TABLE);
    c_short: cover property (tk && REQ.ea_op == cag_pkg::CAG_EA_SHORT && REQ.imm16[7:0] < 8'h20);
    c_refuse: cover property (BUSY && REQ_VALID);
endmodule // cag_top_properties
bind cag_top cag_top_properties chk_u (.MCLK(MCLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .FETCH_BYTES(FETCH_BYTES), .PC_VALID(PC_VALID), .PC(PC), .TBL_ADDR(TBL_ADDR),
    .TBL_RD(TBL_RD), .EA(EA), .BUSY(BUSY));

// ---- test/cag_top_test.sv ----
// Purpose: Self-checking bench for the address generator.
// Assumes: Table memory model on the read port; register file filled before requests.
// Notes: Expected results queue up at request time and are matched as pulses appear.
`timescale 1ns/100ps
module cag_top_test;
    logic MCLK = 1'b0, ARST_N = 1'b0, REQ_VALID = 1'b0, REG_WE = 1'b0, PC_VALID, TBL_RD, BUSY;
    logic [1:0] FETCH_BYTES = 2'h0;
    logic [4:0] REG_WIDX = 5'h00;
    logic [7:0] REG_WDATA = 8'h00, MEM_RDATA, d;
    logic [15:0] PC, TBL_ADDR, PRODUCT, pc_m, a;
    cag_pkg::cag_req_t REQ = '0;
    cag_pkg::cag_ea_t EA;
    logic [7:0] regs [32];
    logic [15:0] pc_q [$];
    logic [16:0] ea_q [$];
    logic [16:0] ea_exp;
    int error_cnt = 0, checks_done = 0, cycles = 0, b;
    cag_top dut_u (.MCLK(MCLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID), .REQ(REQ),
        .FETCH_BYTES(FETCH_BYTES), .MEM_RDATA(MEM_RDATA), .REG_WE(REG_WE), .REG_WIDX(REG_WIDX),
        .REG_WDATA(REG_WDATA), .PC(PC), .PC_VALID(PC_VALID), .TBL_ADDR(TBL_ADDR), .TBL_RD(TBL_RD),
        .EA(EA), .PRODUCT(PRODUCT), .BUSY(BUSY));
    cag_table_mem mem_u (.MCLK(MCLK), .TBL_ADDR(TBL_ADDR), .TBL_RD(TBL_RD), .MEM_RDATA(MEM_RDATA));
    initial begin
        forever #2 MCLK = ~MCLK;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic send(input cag_pkg::cag_pc_op_t p, input cag_pkg::cag_ea_op_t e,
                        input logic [15:0] imm, input logic [7:0] opc, input int bk,
                        input logic hl, input logic [1:0] fb);
        @(posedge MCLK);
        REQ_VALID <= 1'b1;
        REQ <= '{pc_op: p, ea_op: e, imm16: imm, opcode: opc, bank: bk[1:0], pair_hl: hl};
        FETCH_BYTES <= fb;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge MCLK);
            REQ_VALID <= 1'b0;
        end
    endtask
    task automatic pc_req(input cag_pkg::cag_pc_op_t p, input logic [15:0] imm,
                          input logic [7:0] opc, input int bk, input logic [1:0] fb,
                          input logic [15:0] exp);
        send(p, cag_pkg::CAG_EA_NONE, imm, opc, bk, 1'b0, fb);
        pc_q.push_back(exp);
        pc_m = exp;
    endtask
    task automatic ea_req(input cag_pkg::cag_ea_op_t e, input logic [15:0] imm,
                          input logic [7:0] opc, input int bk, input logic hl,
                          input logic [15:0] exp);
        send(cag_pkg::CAG_PC_HOLD, e, imm, opc, bk, hl, 2'h0);
        ea_q.push_back({e == cag_pkg::CAG_EA_UNSIGNED_MULTIPLY_OP || e == cag_pkg::CAG_EA_WORD_DIVISION_OP, exp});
    endtask
    function automatic logic [15:0] pr(input int bk, input int r);
        return {regs[bk * 8 + r + 1], regs[bk * 8 + r]};
    endfunction
    always @(negedge MCLK) begin
        cycles++;
        if (cycles > 3000) begin
            error_cnt++;
            give_verdict();
        end
        if (PC_VALID === 1'b1) chk("pc", PC, pc_q.size() > 0 ? pc_q.pop_front() : ~PC);
        if (EA.valid === 1'b1) begin
            ea_exp = ea_q.size() > 0 ? ea_q.pop_front() : ~{EA.word, EA.addr};
            chk("ea", EA.addr, ea_exp[15:0]);
            chk("ea_hi", EA.addr_hi, ea_exp[15:0] + 16'h0001);
            chk("ea_word", {15'h0000, EA.word}, {15'h0000, ea_exp[16]});
        end
    end
    initial begin
        void'($urandom(19));
        repeat (3) @(posedge MCLK);
        ARST_N <= 1'b1;
        // The design's own reset copy needs two more edges before a write can land.
        repeat (2) @(posedge MCLK);
        for (int i = 0; i < 32; i++) begin
            @(posedge MCLK);
            regs[i] = (i >= 30) ? 8'hFF : 8'($urandom);
            REG_WE <= 1'b1;
            REG_WIDX <= 5'(i);
            REG_WDATA <= regs[i];
        end
        @(posedge MCLK);
        REG_WE <= 1'b0;
        pc_m = 16'h0000;
        for (int f = 1; f < 4; f++) pc_req(cag_pkg::CAG_PC_SEQ, 16'h0000, 8'h00, 0, 2'(f), pc_m + 16'(f));
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : (i == 2) ? 8'h00 : 8'($urandom);
            pc_req(cag_pkg::CAG_PC_REL, {8'h00, d}, 8'h00, 0, 2'h2, pc_m + 16'h0002 + {{8{d[7]}}, d});
        end
        a = 16'($urandom);
        pc_req(cag_pkg::CAG_PC_IMM16, a, 8'h00, 0, 2'h0, a);
        pc_req(cag_pkg::CAG_PC_FAST, ~a, 8'h00, 0, 2'h0, {5'h01, ~a[10:0]});
        b = $urandom % 4;
        pc_req(cag_pkg::CAG_PC_PAIR, 16'h0000, 8'h00, b, 2'h0, pr(b, 0));
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'h1F : 8'($urandom % 32);
            a = 16'h0040 + {7'h00, d, 1'b0};
            pc_req(cag_pkg::CAG_PC_TABLE, 16'h0000, {d[6:0], 1'b0}, 0, 2'h0,
                   {mem_u.tbl_byte(a + 16'h0001), mem_u.tbl_byte(a)});
            send(cag_pkg::CAG_PC_HOLD, cag_pkg::CAG_EA_DIRECT, 16'h1234, 8'h00, 0, 1'b0, 2'h0);
            idle(4);
        end
        a = 16'($urandom);
        ea_req(cag_pkg::CAG_EA_DIRECT, a, 8'h00, 0, 1'b0, a);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h1F : (i == 2) ? 8'h20 : 8'hFF;
            ea_req(cag_pkg::CAG_EA_SHORT, {8'h00, d}, 8'h00, 0, 1'b0, {7'h7F, d < 8'h20, d});
            ea_req(cag_pkg::CAG_EA_SFR, {8'h00, d ^ 8'h30}, 8'h00, 0, 1'b0, {8'hFF, d ^ 8'h30});
        end
        ea_req(cag_pkg::CAG_EA_SHORT, 16'h0010, 8'h00, 0, 1'b0, 16'hFF10);
        ea_req(cag_pkg::CAG_EA_SFR, 16'h00E0, 8'h00, 0, 1'b0, 16'hFFE0);
        for (b = 0; b < 4; b++) begin
            d = 8'($urandom % 8);
            ea_req(cag_pkg::CAG_EA_REG, 16'h0000, d, b, 1'b0, 16'hFEE0 + 16'(b * 8) + 16'(d));
            ea_req(cag_pkg::CAG_EA_INDIRECT, 16'h0000, 8'h00, b, 1'b0, pr(b, 4));
            ea_req(cag_pkg::CAG_EA_INDIRECT, 16'h0000, 8'h00, b, 1'b1, pr(b, 6));
            ea_req(cag_pkg::CAG_EA_BASED, {8'h00, d ^ 8'hF0}, 8'h00, b, 1'b1, pr(b, 6) + {8'h00, d ^ 8'hF0});
            ea_req(cag_pkg::CAG_EA_WORD_DIVISION_OP, 16'h0000, 8'h00, b, 1'b0, 16'hFEE0 + 16'(b * 8));
            ea_req(cag_pkg::CAG_EA_ACC, 16'h0000, 8'h00, b, 1'b0, 16'hFEE1 + 16'(b * 8));
            ea_req(cag_pkg::CAG_EA_UNSIGNED_MULTIPLY_OP, 16'h0000, 8'h00, b, 1'b0, 16'hFEE0 + 16'(b * 8));
            idle(3);
            @(negedge MCLK);
            chk("product", PRODUCT, 16'(regs[b * 8 + 1]) * 16'(regs[b * 8]));
        end
        idle(3);
        chk("pending", 16'(pc_q.size() + ea_q.size()), 16'h0000);
        give_verdict();
    end
endmodule // cag_top_test
